// ==== logic/instruction_timing_model.sv ====
// cycle-accounting lookup of head, tail, clocks and bus access counts
`timescale 1ns/1ps
module instruction_timing_model (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   req_i,
  input  wire timing_pkg::lookup_t    kind_i,
  input  wire timing_pkg::ea_mode_t   src_mode_i,
  input  wire timing_pkg::ea_mode_t   dst_mode_i,
  input  wire timing_pkg::move_class_t src_class_i,
  input  wire timing_pkg::move_class_t dst_class_i,
  input  wire timing_pkg::special_t   special_i,
  input  wire logic                   long_i,
  input  wire logic                   imm_long_i,
  input  wire logic                   pc_base_i,
  input  wire logic [1:0]             index_scale_i,
  input  wire logic                   index_long_i,
  input  wire logic [4:0]             reg_count_i,
  input  wire logic [7:0]             slow_clks_i,
  output logic                        valid_o,
  output logic                        head_neg_o,
  output logic [7:0]                  head_o,
  output logic [7:0]                  tail_o,
  output logic [7:0]                  total_o,
  output logic [5:0]                  reads_o,
  output logic [5:0]                  prefetches_o,
  output logic [5:0]                  writes_o
);

  typedef struct packed {
    logic [7:0] head;
    logic [7:0] tail;
    logic [7:0] total;
    logic [5:0] rd;
    logic [5:0] pf;
    logic [5:0] wr;
    logic       rd_x;
    logic       wr_x;
    logic       tail_neg;
  } entry_t;

  entry_t     ent_d;
  entry_t     ent_q;
  logic [7:0] slow_q;
  logic       long_q;
  logic       req_q;
  logic [7:0] long_add;
  logic [7:0] adj_head;
  logic [7:0] adj_tail;
  logic [7:0] adj_total;
  logic [5:0] bus_x;

  function automatic entry_t mk(input int h, input int t, input int c,
                                input int r, input int p, input int w,
                                input int rx, input int wx);
    entry_t e;
    e.head     = 8'(h);
    e.tail     = 8'(t);
    e.total    = 8'(c);
    e.rd       = 6'(r);
    e.pf       = 6'(p);
    e.wr       = 6'(w);
    e.rd_x     = 1'(rx);
    e.wr_x     = 1'(wx);
    e.tail_neg = 1'b0;
    return e;
  endfunction

  // fetch form; index size, scale and program counter base never enter
  function automatic entry_t fetch_ea(input timing_pkg::ea_mode_t m);
    unique case (m)
      timing_pkg::CA_DATA_REG,
      timing_pkg::CA_ADDR_REG:     return mk(0, 0, 0, 0, 0, 0, 0, 0);
      timing_pkg::CA_IND,
      timing_pkg::CA_POSTINC:      return mk(1, 1, 3, 0, 0, 0, 1, 0);
      timing_pkg::CA_PREDEC:       return mk(2, 2, 4, 0, 0, 0, 1, 0);
      timing_pkg::CA_DISP16,
      timing_pkg::CA_ABS_W:        return mk(1, 3, 5, 0, 1, 0, 1, 0);
      timing_pkg::CA_ABS_L:        return mk(1, 5, 7, 0, 2, 0, 1, 0);
      timing_pkg::CA_BRIEF_IDX,
      timing_pkg::CA_MI_IDX,
      timing_pkg::CA_MI_BASE_IDX:  return mk(4, 2, 8, 0, 1, 0, 1, 0);
      timing_pkg::CA_ALL_SUPP:     return mk(2, 2, 6, 0, 1, 0, 1, 0);
      timing_pkg::CA_MI_D16,
      timing_pkg::CA_MI_D16_BASE:  return mk(1, 3, 7, 0, 2, 0, 1, 0);
      timing_pkg::CA_MI_D32,
      timing_pkg::CA_MI_D32_BASE:  return mk(1, 5, 9, 0, 3, 0, 1, 0);
      timing_pkg::CA_MI_BASE:      return mk(1, 1, 5, 0, 1, 0, 1, 0);
      timing_pkg::CA_D16_BASE_IDX,
      timing_pkg::CA_D16_BASE_SIX: return mk(2, 2, 8, 0, 2, 0, 1, 0);
      timing_pkg::CA_D32_BASE_IDX,
      timing_pkg::CA_D32_BASE_SIX: return mk(1, 3, 9, 0, 3, 0, 1, 0);
      default:                     return mk(0, 0, 0, 0, 0, 0, 0, 0);
    endcase
  endfunction

  // calculate form: fetch form with the read removed from tail and total
  function automatic entry_t calc_ea(input timing_pkg::ea_mode_t m);
    entry_t     e;
    logic [7:0] cut;
    e = fetch_ea(m);
    if (e.rd_x) begin
      e.rd_x  = 1'b0;
      cut     = (e.tail > timing_pkg::BUS_CLKS) ? timing_pkg::BUS_CLKS
                                                : e.tail;
      e.tail  = e.tail - cut;
      e.total = e.total - cut;
    end
    // predecrement still spends its decrement clocks
    if (m == timing_pkg::CA_PREDEC) begin
      e.tail  = 8'h00;
      e.total = 8'h02;
    end
    return e;
  endfunction

  function automatic entry_t imm_fetch(input logic lng);
    if (lng)
      return mk(1, 3, 5, 0, 2, 0, 0, 0);
    return mk(1, 1, 3, 0, 1, 0, 0, 0);
  endfunction

  // serial combination: later head swallows earlier tail
  function automatic entry_t chain(input entry_t a, input entry_t b);
    entry_t     e;
    logic [7:0] ov;
    ov      = (a.tail < b.head) ? a.tail : b.head;
    e       = b;
    e.head  = a.head;
    e.total = a.total + b.total - ov;
    e.rd    = a.rd + b.rd;
    e.pf    = a.pf + b.pf;
    e.wr    = a.wr + b.wr;
    e.rd_x  = a.rd_x | b.rd_x;
    e.wr_x  = a.wr_x | b.wr_x;
    return e;
  endfunction

  // first matching row from the top of the move list
  function automatic entry_t move_row(input timing_pkg::move_class_t s,
                                      input timing_pkg::move_class_t d);
    if (s == timing_pkg::MV_REG && d == timing_pkg::MV_REG)
      return mk(0, 0, 2, 0, 1, 0, 0, 0);
    if (s == timing_pkg::MV_FETCHED && d == timing_pkg::MV_REG)
      return mk(0, 0, 2, 0, 1, 0, 0, 0);
    if (s == timing_pkg::MV_REG && d == timing_pkg::MV_IND)
      return mk(0, 2, 4, 0, 1, 0, 0, 1);
    if (s == timing_pkg::MV_REG && d == timing_pkg::MV_POSTINC)
      return mk(1, 1, 5, 0, 1, 0, 0, 1);
    if (s == timing_pkg::MV_REG && d == timing_pkg::MV_PREDEC)
      return mk(2, 2, 6, 0, 1, 0, 0, 1);
    if (s == timing_pkg::MV_REG && d == timing_pkg::MV_CALC)
      return mk(1, 3, 5, 0, 1, 0, 0, 1);
    if (s == timing_pkg::MV_FETCHED &&
        (d == timing_pkg::MV_IND || d == timing_pkg::MV_POSTINC ||
         d == timing_pkg::MV_PREDEC))
      return mk(2, 2, 6, 0, 1, 0, 0, 1);
    if (s == timing_pkg::MV_IMM && d == timing_pkg::MV_CALC)
      return mk(2, 2, 6, 0, 1, 0, 0, 1);
    return mk(2, 2, 6, 0, 1, 0, 0, 1);
  endfunction

  function automatic entry_t special(input timing_pkg::special_t s,
                                     input logic [4:0] n);
    entry_t     e;
    logic [7:0] n4;
    logic [5:0] n6;
    n4 = 8'({n, 2'b00});
    n6 = 6'(n);
    unique case (s)
      timing_pkg::SP_EXG:          e = mk(2, 0, 4, 0, 1, 0, 0, 0);
      timing_pkg::SP_CTRL_TO_REG:  e = mk(10, 0, 14, 0, 2, 0, 0, 0);
      timing_pkg::SP_REG_TO_CTRL:  e = mk(12, 0, 16, 0, 1, 0, 0, 0);
      timing_pkg::SP_CCR_TO_D,
      timing_pkg::SP_D_TO_CCR,
      timing_pkg::SP_SR_TO_D:      e = mk(2, 0, 4, 0, 1, 0, 0, 0);
      timing_pkg::SP_CCR_TO_EA,
      timing_pkg::SP_SR_TO_EA:     e = mk(0, 2, 4, 0, 1, 1, 0, 0);
      timing_pkg::SP_EA_TO_CCR:    e = mk(0, 0, 4, 0, 1, 0, 0, 0);
      timing_pkg::SP_D_TO_SR:      e = mk(4, 2, 10, 0, 3, 0, 0, 0);
      timing_pkg::SP_EA_TO_SR:     e = mk(0, 2, 10, 0, 3, 0, 0, 0);
      timing_pkg::SP_MRM_W_LOAD:
        e = mk(1, 0, int'(timing_pkg::MRM_W_BASE + n4),
               int'(n6 + 6'h01), 2, 0, 0, 0);
      timing_pkg::SP_MRM_W_STORE:
        e = mk(1, 0, int'(timing_pkg::MRM_W_BASE + n4), 0, 2, int'(n6),
               0, 0);
      timing_pkg::SP_MRM_L_LOAD:
        e = mk(1, 0, int'(timing_pkg::MRM_L_LD_BASE + n4),
               int'(6'({n6[4:0], 1'b0}) + 6'h02), 2, 0, 0, 0);
      timing_pkg::SP_MRM_L_STORE:
        e = mk(1, 2, int'(timing_pkg::MRM_L_ST_BASE + n4), 0, 2,
               int'(6'({n6[4:0], 1'b0})), 0, 0);
      timing_pkg::SP_BLP_W_TO_MEM: e = mk(2, 0, 10, 0, 2, 2, 0, 0);
      timing_pkg::SP_BLP_L_TO_MEM: e = mk(2, 0, 14, 0, 2, 4, 0, 0);
      timing_pkg::SP_BLP_W_TO_REG: e = mk(1, 2, 11, 2, 2, 0, 0, 0);
      timing_pkg::SP_BLP_L_TO_REG: e = mk(1, 2, 19, 4, 2, 0, 0, 0);
      timing_pkg::SP_USP_TO_A,
      timing_pkg::SP_A_TO_USP:     e = mk(0, 0, 2, 0, 1, 0, 0, 0);
      timing_pkg::SP_SWAP:         e = mk(4, 0, 6, 0, 1, 0, 0, 0);
      default:                     e = mk(0, 0, 0, 0, 0, 0, 0, 0);
    endcase
    // status register loads end with a negative tail of two
    e.tail_neg = (s == timing_pkg::SP_D_TO_SR) ||
                 (s == timing_pkg::SP_EA_TO_SR);
    return e;
  endfunction

  always_comb begin
    ent_d = mk(0, 0, 0, 0, 0, 0, 0, 0);
    unique case (kind_i)
      timing_pkg::LK_CALC_EA:  ent_d = calc_ea(src_mode_i);
      timing_pkg::LK_FETCH_EA: ent_d = fetch_ea(src_mode_i);
      timing_pkg::LK_MOVE: begin
        ent_d = move_row(src_class_i, dst_class_i);
        if (src_class_i == timing_pkg::MV_CALC &&
            dst_class_i == timing_pkg::MV_FETCHED) begin
          ent_d = chain(calc_ea(src_mode_i), fetch_ea(dst_mode_i));
          ent_d = chain(ent_d, move_row(src_class_i, dst_class_i));
        end
      end
      timing_pkg::LK_IMM_MOVE: begin
        ent_d = chain(imm_fetch(imm_long_i), calc_ea(dst_mode_i));
        ent_d = chain(ent_d, move_row(timing_pkg::MV_IMM,
                                      timing_pkg::MV_CALC));
      end
      timing_pkg::LK_SPECIAL:  ent_d = special(special_i, reg_count_i);
      default:                 ent_d = mk(0, 0, 0, 0, 0, 0, 0, 0);
    endcase
  end

  // stage one: latch looked-up entry and qualifiers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ent_q  <= '0;
      slow_q <= 8'h00;
      long_q <= 1'b0;
      req_q  <= 1'b0;
    end else begin
      ent_q  <= ent_d;
      slow_q <= slow_clks_i;
      long_q <= long_i;
      req_q  <= req_i;
    end
  end

  // a long operand access flagged by rd_x or wr_x adds two clocks, once per entry even with both read and write
  assign bus_x    = long_q ? timing_pkg::LONG_CYCLES
                           : timing_pkg::WORD_CYCLES;
  assign long_add = (long_q && (ent_q.rd_x || ent_q.wr_x)) ?
                    timing_pkg::LONG_EXTRA : 8'h00;

  ea_slow_adjust u_adjust (
    .head_i     (ent_q.head),
    .tail_i     (ent_q.tail),
    .total_i    (ent_q.total),
    .long_add_i (long_add),
    .slow_add_i (slow_q),
    .head_o     (adj_head),
    .tail_o     (adj_tail),
    .total_o    (adj_total)
  );

  // stage two: separate registered outputs
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid_o      <= 1'b0;
      head_neg_o   <= 1'b0;
      head_o       <= 8'h00;
      tail_o       <= 8'h00;
      total_o      <= 8'h00;
      reads_o      <= 6'h00;
      prefetches_o <= 6'h00;
      writes_o     <= 6'h00;
    end else begin
      valid_o      <= req_q;
      head_neg_o   <= ent_q.tail_neg;
      head_o       <= adj_head;
      tail_o       <= adj_tail;
      total_o      <= adj_total;
      reads_o      <= ent_q.rd_x ? ent_q.rd + bus_x : ent_q.rd;
      prefetches_o <= ent_q.pf;
      writes_o     <= ent_q.wr_x ? ent_q.wr + bus_x : ent_q.wr;
    end
  end

endmodule

// ==== pkg/timing_pkg.sv ====
// timing constants, entry codes and table layout for the timing model
package timing_pkg;

  // calculate-address mode codes
  typedef enum logic [4:0] {
    CA_DATA_REG     = 5'h00,
    CA_ADDR_REG     = 5'h01,
    CA_IND          = 5'h02,
    CA_POSTINC      = 5'h03,
    CA_PREDEC       = 5'h04,
    CA_DISP16       = 5'h05,
    CA_ABS_W        = 5'h06,
    CA_ABS_L        = 5'h07,
    CA_BRIEF_IDX    = 5'h08,
    CA_ALL_SUPP     = 5'h09,
    CA_MI_D16       = 5'h0a,
    CA_MI_D32       = 5'h0b,
    CA_MI_BASE      = 5'h0c,
    CA_MI_IDX       = 5'h0d,
    CA_MI_BASE_IDX  = 5'h0e,
    CA_MI_D16_BASE  = 5'h0f,
    CA_MI_D32_BASE  = 5'h10,
    CA_D16_BASE_IDX = 5'h11,
    CA_D32_BASE_IDX = 5'h12,
    CA_D16_BASE_SIX = 5'h13,
    CA_D32_BASE_SIX = 5'h14
  } ea_mode_t;

  // source / destination classes for plain moves
  typedef enum logic [2:0] {
    MV_REG      = 3'h0,
    MV_IND      = 3'h1,
    MV_POSTINC  = 3'h2,
    MV_PREDEC   = 3'h3,
    MV_CALC     = 3'h4,
    MV_FETCHED  = 3'h5,
    MV_IMM      = 3'h6
  } move_class_t;

  // lookup kind
  typedef enum logic [2:0] {
    LK_CALC_EA  = 3'h0,
    LK_FETCH_EA = 3'h1,
    LK_MOVE     = 3'h2,
    LK_SPECIAL  = 3'h3,
    LK_IMM_MOVE = 3'h4
  } lookup_t;

  // special-purpose move entries
  typedef enum logic [4:0] {
    SP_EXG          = 5'h00,
    SP_CTRL_TO_REG  = 5'h01,
    SP_REG_TO_CTRL  = 5'h02,
    SP_CCR_TO_D     = 5'h03,
    SP_CCR_TO_EA    = 5'h04,
    SP_D_TO_CCR     = 5'h05,
    SP_EA_TO_CCR    = 5'h06,
    SP_SR_TO_D      = 5'h07,
    SP_SR_TO_EA     = 5'h08,
    SP_D_TO_SR      = 5'h09,
    SP_EA_TO_SR     = 5'h0a,
    SP_MRM_W_LOAD   = 5'h0b,
    SP_MRM_W_STORE  = 5'h0c,
    SP_MRM_L_LOAD   = 5'h0d,
    SP_MRM_L_STORE  = 5'h0e,
    SP_BLP_W_TO_MEM = 5'h0f,
    SP_BLP_W_TO_REG = 5'h10,
    SP_BLP_L_TO_MEM = 5'h11,
    SP_BLP_L_TO_REG = 5'h12,
    SP_USP_TO_A     = 5'h13,
    SP_A_TO_USP     = 5'h14,
    SP_SWAP         = 5'h15
  } special_t;

  localparam int unsigned VAL_W = 8;
  localparam int unsigned CNT_W = 6;

  // bus access clocks and long adjustment
  localparam logic [7:0] BUS_CLKS      = 8'h02;
  localparam logic [7:0] LONG_EXTRA    = 8'h02;
  localparam logic [5:0] WORD_CYCLES   = 6'h01;
  localparam logic [5:0] LONG_CYCLES   = 6'h02;

  // multi-register move base and per-register clocks
  localparam logic [7:0] MRM_W_BASE    = 8'h08;
  localparam logic [7:0] MRM_L_LD_BASE = 8'h0c;
  localparam logic [7:0] MRM_L_ST_BASE = 8'h0a;
  localparam logic [7:0] MRM_PER_REG   = 8'h04;

  // result latency of the model in clock cycles
  localparam int unsigned LATENCY = 2;

endpackage

// ==== logic/ea_slow_adjust.sv ====
// head/tail/total adjustment for slow prefetches and long operands
`timescale 1ns/1ps
module ea_slow_adjust (
  input  wire logic [7:0] head_i,
  input  wire logic [7:0] tail_i,
  input  wire logic [7:0] total_i,
  input  wire logic [7:0] long_add_i,
  input  wire logic [7:0] slow_add_i,
  output logic      [7:0] head_o,
  output logic      [7:0] tail_o,
  output logic      [7:0] total_o
);
  logic [7:0] spill;

  always_comb begin
    // head absorbs slow clocks first, overflow goes to tail and total
    if (slow_add_i <= head_i) begin
      head_o = head_i - slow_add_i;
      spill  = 8'h00;
    end else begin
      head_o = 8'h00;
      spill  = slow_add_i - head_i;
    end
    tail_o  = tail_i + long_add_i + spill;
    total_o = total_i + long_add_i + spill;
  end
endmodule

// ==== bench/timing_monitor.sv ====
// concurrent checks on the timing lookup ports
`timescale 1ns/1ps
module timing_monitor (
  input wire logic                 sys_clk_i,
  input wire logic                 rstn_i,
  input wire logic                 req_i,
  input wire timing_pkg::lookup_t  kind_i,
  input wire timing_pkg::ea_mode_t src_mode_i,
  input wire timing_pkg::special_t special_i,
  input wire logic [4:0]           reg_count_i,
  input wire logic [7:0]           slow_clks_i,
  input wire logic                 valid_o,
  input wire logic                 head_neg_o,
  input wire logic [7:0]           head_o,
  input wire logic [7:0]           tail_o,
  input wire logic [7:0]           total_o,
  input wire logic [5:0]           reads_o,
  input wire logic [5:0]           prefetches_o,
  input wire logic [5:0]           writes_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic calc;
  logic spec;
  assign calc = req_i && kind_i == timing_pkg::LK_CALC_EA;
  assign spec = req_i && kind_i == timing_pkg::LK_SPECIAL && slow_clks_i == 0;

  a_valid_delay: assert property (req_i |-> ##2 valid_o)
    else $error("result not flagged two cycles after request");
  a_idle_quiet: assert property (!req_i |-> ##2 !valid_o)
    else $error("result flagged without request");
  a_calc_noread: assert property (calc |-> ##2 reads_o == 6'h00)
    else $error("calculate lookup reports reads");
  a_brief_calc: assert property (
    calc && slow_clks_i == 0 && src_mode_i == timing_pkg::CA_BRIEF_IDX |->
    ##2 {head_o, tail_o, total_o, prefetches_o} == {24'h040006, 6'h01})
    else $error("brief indexed calculate timing wrong");
  a_d32_idx: assert property (
    calc && slow_clks_i == 0 && src_mode_i == timing_pkg::CA_D32_BASE_IDX |->
    ##2 {head_o, tail_o, total_o, prefetches_o} == {24'h010107, 6'h03})
    else $error("d32 base index calculate timing wrong");
  a_d16_six: assert property (
    calc && slow_clks_i == 0 && src_mode_i == timing_pkg::CA_D16_BASE_SIX |->
    ##2 {head_o, tail_o, total_o, prefetches_o} == {24'h020006, 6'h02})
    else $error("d16 scaled index calculate timing wrong");
  a_slow_head: assert property (
    calc && src_mode_i == timing_pkg::CA_BRIEF_IDX && slow_clks_i <= 4 |->
    ##2 head_o == 8'h04 - $past(slow_clks_i, 2) && total_o == 8'h06)
    else $error("slow prefetch not taken from head");
  a_mrm_load: assert property (
    spec && special_i == timing_pkg::SP_MRM_L_LOAD |-> ##2
    total_o == 8'h0c + {$past(reg_count_i, 2), 2'b00} &&
    reads_o == {$past(reg_count_i, 2), 1'b0} + 6'h02)
    else $error("long multi load count wrong");
  a_mrm_store: assert property (
    spec && special_i == timing_pkg::SP_MRM_L_STORE |-> ##2
    total_o == 8'h0a + {$past(reg_count_i, 2), 2'b00} &&
    writes_o == {$past(reg_count_i, 2), 1'b0} && tail_o == 8'h02)
    else $error("long multi store count wrong");
  a_blp_reg: assert property (
    spec && special_i == timing_pkg::SP_BLP_W_TO_REG |->
    ##2 total_o == 8'h0b && reads_o == 6'h02)
    else $error("byte-lane word load timing wrong");
  a_bus_sum: assert property (valid_o |-> int'(total_o) >=
    2 * (int'(reads_o) + int'(prefetches_o) + int'(writes_o)))
    else $error("total below its bus access time");
endmodule
bind instruction_timing_model timing_monitor i_mon (.*);

// ==== bench/prefetch_bus_model.sv ====
// slow prefetch bus: extra clocks from wait states of each fetch
`timescale 1ns/1ps
module prefetch_bus_model (
  input  wire logic [2:0] wait_i,
  input  wire logic [5:0] fetch_cnt_i,
  output logic      [7:0] slow_clks_o
);
  // a fetch is two clocks plus waits; only the waits are extra
  assign slow_clks_o = 8'(wait_i) * 8'(fetch_cnt_i);
endmodule

// ==== bench/instruction_timing_model_test.sv ====
// self-checking bench for the instruction timing lookup
`timescale 1ns/1ps
module instruction_timing_model_test;
  logic                    sys_clk_i, rstn_i, req_i, long_i, imm_long_i;
  logic                    pc_base_i, index_long_i, valid_o, head_neg_o;
  timing_pkg::lookup_t     kind_i;
  timing_pkg::ea_mode_t    src_mode_i, dst_mode_i;
  timing_pkg::move_class_t src_class_i, dst_class_i;
  timing_pkg::special_t    special_i;
  logic [1:0]              index_scale_i;
  logic [4:0]              reg_count_i;
  logic [7:0]              slow_clks_i, head_o, tail_o, total_o;
  logic [5:0]              reads_o, prefetches_o, writes_o, fetch_cnt;
  logic [2:0]              wait_st;
  logic [42:0]             exp_q[$];
  logic [42:0]             got, want;
  int                      error_cnt, num_checks, cyc, n;

  instruction_timing_model i_dut (.*);
  prefetch_bus_model i_bus (.wait_i(wait_st), .fetch_cnt_i(fetch_cnt),
                            .slow_clks_o(slow_clks_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [42:0] ex(input int h, t, c, r, p, w);
    return {1'b0, 8'(h), 8'(t), 8'(c), 6'(r), 6'(p), 6'(w)};
  endfunction

  task automatic look(input timing_pkg::lookup_t k,
                      input timing_pkg::ea_mode_t sm, dm,
                      input timing_pkg::move_class_t sc, dc,
                      input timing_pkg::special_t sp, input logic lg,
                      input int nr, ws, nf, input logic [42:0] e);
    @(posedge sys_clk_i);
    #1;
    req_i = 1'b1;
    kind_i = k;
    src_mode_i = sm;
    dst_mode_i = dm;
    src_class_i = sc;
    dst_class_i = dc;
    special_i = sp;
    long_i = lg;
    imm_long_i = lg;
    reg_count_i = 5'(nr);
    wait_st = 3'(ws);
    fetch_cnt = 6'(nf);
    pc_base_i = 1'($urandom);
    index_scale_i = 2'($urandom);
    index_long_i = 1'($urandom);
    exp_q.push_back(e);
  endtask

  task automatic calc(input timing_pkg::lookup_t k,
                      input timing_pkg::ea_mode_t m, input logic lg,
                      input int ws, nf, input logic [42:0] e);
    look(k, m, m, timing_pkg::MV_REG, timing_pkg::MV_REG,
         timing_pkg::SP_EXG, lg, 0, ws, nf, e);
  endtask

  task automatic mv(input timing_pkg::lookup_t k,
                    input timing_pkg::move_class_t sc, dc,
                    input timing_pkg::ea_mode_t sm, dm, input logic lg,
                    input logic [42:0] e);
    look(k, sm, dm, sc, dc, timing_pkg::SP_EXG, lg, 0, 0, 0, e);
  endtask

  task automatic spc(input timing_pkg::special_t sp, input int nr,
                     input logic [42:0] e);
    look(timing_pkg::LK_SPECIAL, timing_pkg::CA_DATA_REG,
         timing_pkg::CA_DATA_REG, timing_pkg::MV_REG, timing_pkg::MV_REG,
         sp, 1'b0, nr, 0, 0, e);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0 && exp_q.size() == 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // oldest expectation is compared with every flagged result
  always @(negedge sys_clk_i) begin
    if (valid_o === 1'b1) begin
      got = {head_neg_o, head_o, tail_o, total_o, reads_o, prefetches_o,
             writes_o};
      want = exp_q.size() > 0 ? exp_q.pop_front() : '1;
      num_checks++;
      if (got !== want) begin
        error_cnt++;
        $display("mismatch t=%0t exp=%h got=%h", $time, want, got);
      end
    end
  end

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    {rstn_i, req_i, long_i, imm_long_i, pc_base_i, index_long_i} = '0;
    {index_scale_i, reg_count_i, wait_st, fetch_cnt} = '0;
    kind_i = timing_pkg::LK_CALC_EA;
    src_mode_i = timing_pkg::CA_DATA_REG;
    dst_mode_i = timing_pkg::CA_DATA_REG;
    src_class_i = timing_pkg::MV_REG;
    dst_class_i = timing_pkg::MV_REG;
    special_i = timing_pkg::SP_EXG;
    void'($urandom(32'h46f2));
    repeat (6) @(posedge sys_clk_i);
    #1;
    rstn_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      calc(timing_pkg::LK_CALC_EA, timing_pkg::CA_BRIEF_IDX, 0, 0, 0,
           ex(4, 0, 6, 0, 1, 0));
    end
    calc(timing_pkg::LK_CALC_EA, timing_pkg::CA_D32_BASE_IDX, 0, 0, 0,
         ex(1, 1, 7, 0, 3, 0));
    calc(timing_pkg::LK_CALC_EA, timing_pkg::CA_D16_BASE_SIX, 0, 0, 0,
         ex(2, 0, 6, 0, 2, 0));
    calc(timing_pkg::LK_FETCH_EA, timing_pkg::CA_BRIEF_IDX, 0, 0, 0,
         ex(4, 2, 8, 1, 1, 0));
    calc(timing_pkg::LK_FETCH_EA, timing_pkg::CA_BRIEF_IDX, 1, 0, 0,
         ex(4, 4, 10, 2, 1, 0));
    calc(timing_pkg::LK_FETCH_EA, timing_pkg::CA_D32_BASE_IDX, 1, 0, 0,
         ex(1, 5, 11, 2, 3, 0));
    calc(timing_pkg::LK_CALC_EA, timing_pkg::CA_BRIEF_IDX, 0, 3, 1,
         ex(1, 0, 6, 0, 1, 0));
    calc(timing_pkg::LK_CALC_EA, timing_pkg::CA_BRIEF_IDX, 0, 6, 1,
         ex(0, 2, 8, 0, 1, 0));
    calc(timing_pkg::LK_CALC_EA, timing_pkg::CA_D32_BASE_IDX, 0, 1, 3,
         ex(0, 3, 9, 0, 3, 0));
    mv(timing_pkg::LK_MOVE, timing_pkg::MV_REG, timing_pkg::MV_REG,
       timing_pkg::CA_DATA_REG, timing_pkg::CA_DATA_REG, 0,
       ex(0, 0, 2, 0, 1, 0));
    mv(timing_pkg::LK_MOVE, timing_pkg::MV_REG, timing_pkg::MV_POSTINC,
       timing_pkg::CA_DATA_REG, timing_pkg::CA_DATA_REG, 0,
       ex(1, 1, 5, 0, 1, 1));
    mv(timing_pkg::LK_MOVE, timing_pkg::MV_REG, timing_pkg::MV_IND,
       timing_pkg::CA_DATA_REG, timing_pkg::CA_DATA_REG, 1,
       ex(0, 4, 6, 0, 1, 2));
    mv(timing_pkg::LK_MOVE, timing_pkg::MV_FETCHED, timing_pkg::MV_PREDEC,
       timing_pkg::CA_DATA_REG, timing_pkg::CA_DATA_REG, 0,
       ex(2, 2, 6, 0, 1, 1));
    mv(timing_pkg::LK_MOVE, timing_pkg::MV_CALC, timing_pkg::MV_FETCHED,
       timing_pkg::CA_IND, timing_pkg::CA_IND, 0,
       ex(1, 2, 10, 1, 1, 1));
    mv(timing_pkg::LK_IMM_MOVE, timing_pkg::MV_IMM, timing_pkg::MV_CALC,
       timing_pkg::CA_DATA_REG, timing_pkg::CA_IND, 0,
       ex(1, 2, 10, 0, 2, 1));
    mv(timing_pkg::LK_IMM_MOVE, timing_pkg::MV_IMM, timing_pkg::MV_CALC,
       timing_pkg::CA_DATA_REG, timing_pkg::CA_IND, 1,
       ex(1, 4, 14, 0, 3, 2));
    spc(timing_pkg::SP_MRM_L_LOAD, 1, ex(1, 0, 16, 4, 2, 0));
    spc(timing_pkg::SP_MRM_L_LOAD, 16, ex(1, 0, 76, 34, 2, 0));
    for (int i = 0; i < 3; i++) begin
      n = $urandom_range(15, 1);
      spc(timing_pkg::SP_MRM_L_STORE, n,
          ex(1, 2, 10 + 4 * n, 0, 2, 2 * n));
    end
    spc(timing_pkg::SP_BLP_W_TO_REG, 0, ex(1, 2, 11, 2, 2, 0));
    spc(timing_pkg::SP_BLP_L_TO_REG, 0, ex(1, 2, 19, 4, 2, 0));
    spc(timing_pkg::SP_BLP_W_TO_MEM, 0, ex(2, 0, 10, 0, 2, 2));
    spc(timing_pkg::SP_BLP_L_TO_MEM, 0, ex(2, 0, 14, 0, 2, 4));
    spc(timing_pkg::SP_D_TO_SR, 0,
        ex(4, 2, 10, 0, 3, 0) | 43'h400_0000_0000);
    @(posedge sys_clk_i);
    #1;
    req_i = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    results();
  end
endmodule
